// File: design/pio_pkg.sv
/*
 shared constants and carrier types for the programmed io channel and its
 multiplexed block-transfer channel.
 assumes a 16-bit processor with an accumulator, an instruction register and
 a memory address/data register pair that can be lent to the channel.
*/
// Summary of operation
// - eight select lines address up to 255 controllers
// - select from instruction, data from accumulator, together
// - output sends accumulator, input returns into accumulator
// - exchange only with currently addressed controller
// - interrogate returns highest-priority requesting controller address
// - multiplexed channel serves sixteen controllers autonomously
// - multiplexed transfers only between instructions, same lines
// - two control words: address, length, direction/type
// - burst or single transfers, byte or word
// - byte mode packs/unpacks two bytes per word
// - decrement length; zero raises controller interrupt
// - on request stall processor, mimic io instruction
// - memory reached through processor address/data registers
`default_nettype none
package pio_pkg;
    localparam int SEL_W = 8;
    localparam int DATA_W = 16;
    localparam int MUX_CH = 16;
    localparam int CH_W = 4;
    localparam logic [7:0] SEL_IDLE = 8'h00;
    // control word 1 field positions
    localparam int CW_DIR_BIT = 15;
    localparam int CW_BYTE_BIT = 14;
    localparam int CW_BURST_BIT = 13;
    localparam int CW_LEN_W = 13;
    localparam logic [15:0] CW_RST = 16'h0000;

    typedef enum logic [1:0] {PIO_NONE, PIO_OUT, PIO_IN, PIO_ASK} pio_op_e;

    typedef struct packed {
        pio_op_e op;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] data;
    } pio_req_s;

    typedef struct packed {
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] data;
        logic wr;
        logic rd;
    } pio_bus_s;

    typedef struct packed {
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic wr;
        logic rd;
    } pio_mem_s;

    typedef struct packed {
        logic [CH_W-1:0] ch;
        logic [DATA_W-1:0] word;
        logic last;
    } pio_word_s;
endpackage
`default_nettype wire

// File: design/pio_channel.sv
/*
 programmed io channel with multiplexed block-transfer channel sharing it.
 assumes the processor presents one io request per instruction gap, holds it
 until done, and obeys procHold; memory answers reads in the same cycle as rd.
 controller data appears on devData in the same cycle as a read strobe.
*/
`default_nettype none
module pio_channel #(
    parameter int MUX_N = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire pio_pkg::pio_req_s procReq,
    input wire logic instrGap,
    output logic procDone,
    output logic [15:0] procAcc,
    output logic procHold,
    output pio_pkg::pio_bus_s devBus,
    input wire logic [15:0] devData,
    input wire logic [254:0] devShareReq,
    input wire logic [15:0] muxSvcReq,
    output pio_pkg::pio_mem_s memBus,
    input wire logic [15:0] memRdata,
    input wire logic cwWrite,
    input wire logic [3:0] cwChan,
    input wire logic cwSel,
    input wire logic [15:0] cwData,
    input wire logic [15:0] cwEnable,
    output logic [15:0] blockIrq
);
    import pio_pkg::*;

    // ==================================================
    // input synchronisers
    logic [15:0] svcMeta_q, svcSync_q;
    logic [254:0] shrMeta_q, shrSync_q;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            svcMeta_q <= '0;
            svcSync_q <= '0;
            shrMeta_q <= '0;
            shrSync_q <= '0;
        end
        else
        begin
            svcMeta_q <= muxSvcReq;
            svcSync_q <= svcMeta_q;
            shrMeta_q <= devShareReq;
            shrSync_q <= shrMeta_q;
        end
    end

    // ==================================================
    // control words and priority
    logic [15:0] addrW_q [MUX_N];
    logic [15:0] ctlW_q [MUX_N];
    logic [15:0] irq_q;
    logic [MUX_N-1:0] pend;
    logic anyPend;
    logic [3:0] winCh;
    logic [7:0] askSel;
    // only enabled, unfinished blocks are served; a stale synced request cannot re-take a done block
    assign pend = svcSync_q[MUX_N-1:0] & cwEnable[MUX_N-1:0] & ~irq_q[MUX_N-1:0];
    assign anyPend = |pend;
    always_comb
    begin
        winCh = 4'h0;
        for (int i = MUX_N - 1; i >= 0; i--)
            if (pend[i])
                winCh = 4'(i);
    end
    always_comb
    begin
        askSel = SEL_IDLE;
        for (int i = 254; i >= 0; i--)
            if (shrSync_q[i])
                askSel = 8'(i + 1);
    end

    // ==================================================
    // sequencer
    typedef enum {S_IDLE, S_PIO, S_PIN, S_MRD, S_MWAIT, S_DOUT, S_DIN, S_MWR, S_REL, S_DONE} pio_st_e;
    pio_st_e st_q;
    logic [3:0] ch_q;
    logic half_q;
    logic [15:0] pack_q;
    logic [15:0] wordOut_q;
    pio_bus_s bus_q;
    pio_mem_s mem_q;
    logic done_q, hold_q;
    logic [15:0] acc_q;
    logic [15:0] curCtl, curAddr, devByteWord;
    logic isByte, isIn, isBurst, lenZeroNext, advWord;
    assign curCtl = ctlW_q[ch_q];
    assign curAddr = addrW_q[ch_q];
    assign isIn = curCtl[CW_DIR_BIT];
    assign isByte = curCtl[CW_BYTE_BIT];
    assign isBurst = curCtl[CW_BURST_BIT];
    assign lenZeroNext = (curCtl[CW_LEN_W-1:0] == 13'h0001);
    // low byte first, high byte second, on both directions
    assign devByteWord = !isByte ? devData : (half_q ? {devData[7:0], pack_q[7:0]} : {8'h00, devData[7:0]});
    assign advWord = !isByte || half_q;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= S_IDLE;
            ch_q <= 4'h0;
            half_q <= 1'b0;
            pack_q <= 16'h0000;
            wordOut_q <= 16'h0000;
            bus_q <= '0;
            mem_q <= '0;
            done_q <= 1'b0;
            hold_q <= 1'b0;
            acc_q <= 16'h0000;
            irq_q <= 16'h0000;
            for (int i = 0; i < MUX_N; i++)
            begin
                addrW_q[i] <= 16'h0000;
                ctlW_q[i] <= CW_RST;
            end
        end
        else
        begin
            done_q <= 1'b0;
            bus_q.wr <= 1'b0;
            bus_q.rd <= 1'b0;
            mem_q.wr <= 1'b0;
            mem_q.rd <= 1'b0;
            if (cwWrite && st_q == S_IDLE)
            begin
                if (cwSel)
                    ctlW_q[cwChan] <= cwData;
                else
                    addrW_q[cwChan] <= cwData;
                if (cwSel && cwData[CW_LEN_W-1:0] != 13'h0000)
                    irq_q[cwChan] <= 1'b0;
            end
            case (st_q)
                S_IDLE:
                begin
                    // stealing waits for an instruction boundary
                    if (instrGap && anyPend && !cwWrite)
                    begin
                        hold_q <= 1'b1;
                        ch_q <= winCh;
                        half_q <= 1'b0;
                        st_q <= ctlW_q[winCh][CW_DIR_BIT] ? S_DIN : S_MRD;
                    end
                    else if (instrGap && procReq.op != PIO_NONE && !done_q)
                    begin
                        st_q <= S_PIO;
                    end
                end
                S_PIO:
                begin
                    // select from instruction, data from accumulator, same cycle
                    bus_q.sel <= procReq.sel;
                    bus_q.data <= procReq.data;
                    bus_q.wr <= (procReq.op == PIO_OUT);
                    bus_q.rd <= (procReq.op == PIO_IN);
                    if (procReq.op == PIO_ASK)
                    begin
                        acc_q <= {8'h00, askSel};
                        st_q <= S_DONE;
                    end
                    else
                        st_q <= (procReq.op == PIO_IN) ? S_PIN : S_DONE;
                end
                S_PIN:
                begin
                    acc_q <= devData;
                    st_q <= S_DONE;
                end
                S_DONE:
                begin
                    done_q <= 1'b1;
                    st_q <= S_IDLE;
                end
                S_MRD:
                begin
                    if (isByte && half_q)
                        st_q <= S_DOUT;
                    else
                    begin
                        mem_q.addr <= curAddr;
                        mem_q.rd <= 1'b1;
                        st_q <= S_MWAIT;
                    end
                end
                S_MWAIT:
                begin
                    wordOut_q <= memRdata;
                    st_q <= S_DOUT;
                end
                S_DOUT:
                begin
                    // controller sees an ordinary output instruction
                    bus_q.sel <= {4'h0, ch_q} + 8'h01;
                    bus_q.data <= !isByte ? wordOut_q : (half_q ? {8'h00, wordOut_q[15:8]} : {8'h00, wordOut_q[7:0]});
                    bus_q.wr <= 1'b1;
                    st_q <= S_MWR;
                end
                S_DIN:
                begin
                    bus_q.sel <= {4'h0, ch_q} + 8'h01;
                    bus_q.rd <= 1'b1;
                    st_q <= S_MWR;
                end
                S_MWR:
                begin
                    if (isIn)
                    begin
                        pack_q <= devByteWord;
                        if (advWord)
                        begin
                            mem_q.addr <= curAddr;
                            mem_q.data <= devByteWord;
                            mem_q.wr <= 1'b1;
                        end
                    end
                    half_q <= isByte ? !half_q : 1'b0;
                    if (advWord)
                    begin
                        addrW_q[ch_q] <= curAddr + 16'h0001;
                        ctlW_q[ch_q][CW_LEN_W-1:0] <= curCtl[CW_LEN_W-1:0] - 13'h0001;
                        if (lenZeroNext)
                            irq_q[ch_q] <= 1'b1;
                    end
                    // burst keeps the processor halted while requests and block length remain
                    if (isByte && !half_q)
                        st_q <= isIn ? S_DIN : S_MRD;
                    else if (isBurst && !lenZeroNext && pend[ch_q])
                        st_q <= isIn ? S_DIN : S_MRD;
                    else
                        st_q <= S_REL; // memory write still lands under hold
                end
                S_REL:
                begin
                    hold_q <= 1'b0;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign procDone = done_q;
    assign procAcc = acc_q;
    assign procHold = hold_q;
    assign devBus = bus_q;
    assign memBus = mem_q;
    assign blockIrq = irq_q;

    // ==================================================
    // checks
    a_hold_in_gap: assert property (@(posedge clk) disable iff (sys_rst) $rose(procHold) |-> $past(instrGap))
        else $error("hold raised outside instruction gap");
    a_irq_on_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == S_MWR && advWord && lenZeroNext) |=> blockIrq[$past(ch_q)])
        else $error("block interrupt missing at zero length");
    a_in_to_acc: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == S_PIO && procReq.op == PIO_IN) |=> devBus.rd ##1 (procAcc == $past(devData)))
        else $error("input word not returned to accumulator");
    a_out_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == S_PIO && procReq.op == PIO_OUT) |=> devBus.wr && devBus.sel == $past(procReq.sel)
        && devBus.data == $past(procReq.data))
        else $error("output select or data wrong");
    a_mux_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (devBus.wr || devBus.rd) && procHold |-> devBus.sel == {4'h0, ch_q} + 8'h01)
        else $error("stolen cycle addressed wrong controller");
    a_prio_low: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == S_IDLE && instrGap && anyPend && !cwWrite) |=> ((($past(pend) >> ch_q) & 16'h0001) == 16'h0001)
        && (($past(pend) & ((16'h0001 << ch_q) - 16'h0001)) == 16'h0000))
        else $error("priority order violated");
    a_mem_via_reg: assert property (@(posedge clk) disable iff (sys_rst) memBus.wr |-> procHold)
        else $error("memory written without holding processor");
    a_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(procHold) |-> $past(cwEnable[winCh]))
        else $error("disabled channel served");
    a_ask_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == S_PIO && procReq.op == PIO_ASK) |=> procAcc == {8'h00, $past(askSel)})
        else $error("interrogation returned wrong address");
    c_pio_out: cover property (@(posedge clk) disable iff (sys_rst) devBus.wr && !procHold);
    c_byte_in: cover property (@(posedge clk) disable iff (sys_rst) st_q == S_MWR && isIn && isByte && half_q);
    c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(blockIrq[0]));
endmodule // pio_channel
`default_nettype wire

// File: verif/pio_dev_model.sv
/*
 far-side model: addressed device controllers and the memory behind the
 processor's memory registers.
 assumes pio_pkg is compiled first and the bench pokes mem directly.
*/
`default_nettype none
module pio_dev_model (
    input wire logic clk,
    input wire pio_pkg::pio_bus_s devBus,
    input wire pio_pkg::pio_mem_s memBus,
    input wire logic [15:0] svcSet,
    input wire logic [3:0] svcUnits,
    output logic [15:0] devData,
    output logic [15:0] memRdata,
    output logic [15:0] muxSvcReq
);
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;
    logic [15:0] mem [0:255];
    logic [15:0] junk = 16'hA5A5;
    logic [15:0] lastData;
    logic [7:0] lastSel;
    logic [7:0] rdCnt = 8'h00;
    logic [7:0] memWrCnt = 8'h00;
    logic [7:0] memAddrQ;
    logic devRdQ = 1'b0;
    logic memRdQ = 1'b0;
    logic [3:0] units [0:15];
    // ==========================================
    // answers
    // ==========================================
    // only the selected controller answers; read count makes every word unique
    assign devData = (devBus.rd || devRdQ) ? {devBus.sel, rdCnt} : junk;
    // last word held one cycle after rd, then released lines show a pattern that moves every cycle
    assign memRdata = memBus.rd ? mem[memBus.addr[7:0]] : memRdQ ? mem[memAddrQ] : ~junk;
    // request stays up until its units have crossed the shared lines
    always_comb
    begin
        for (int i = 0; i < 16; i++)
            muxSvcReq[i] = units[i] != 4'h0;
    end
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 16'h0000;
        for (int i = 0; i < 16; i++)
            units[i] = 4'h0;
    end
    always @(posedge clk)
    begin
        junk <= {junk[14:0], ~junk[15]};
        devRdQ <= devBus.rd;
        memRdQ <= memBus.rd;
        if (devRdQ)
            rdCnt <= rdCnt + 8'h01;
        if (memBus.rd)
            memAddrQ <= memBus.addr[7:0];
        if (memBus.wr)
        begin
            mem[memBus.addr[7:0]] <= memBus.data;
            memWrCnt <= memWrCnt + 8'h01;
        end
        if (devBus.wr)
        begin
            lastSel <= devBus.sel;
            lastData <= devBus.data;
        end
        for (int i = 0; i < 16; i++)
            if (svcSet[i])
                units[i] <= svcUnits;
            else if ((devBus.wr || devBus.rd) && devBus.sel == 8'(i + 1) && units[i] != 4'h0)
                units[i] <= units[i] - 4'h1;
    end
endmodule // pio_dev_model
`default_nettype wire

// File: verif/test_programmed_and_multiplexed_io_channel.sv
/*
 self-checking bench: programmed transfers, interrogation, multiplexed
 word and byte blocks.
 assumes pio_pkg, pio_channel and pio_dev_model are compiled before it.
*/
`default_nettype none
module test_programmed_and_multiplexed_io_channel;
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;
    logic clk, sysRst, instrGap, procDone, procHold, cwWrite, cwSel;
    pio_req_s procReq;
    pio_bus_s devBus;
    pio_mem_s memBus;
    logic [15:0] procAcc, devData, memRdata, muxSvcReq, cwData, cwEnable, blockIrq, svcSet;
    logic [254:0] devShareReq;
    logic [3:0] cwChan, svcUnits;
    logic [23:0] seen [0:1];
    int errors = 0;
    int samplesChecked = 0;
    int gapLow = 0;
    pio_channel #(.MUX_N(16)) pio_channel_inst (.clk(clk), .sys_rst(sysRst), .procReq(procReq),
        .instrGap(instrGap), .procDone(procDone), .procAcc(procAcc), .procHold(procHold), .devBus(devBus),
        .devData(devData), .devShareReq(devShareReq), .muxSvcReq(muxSvcReq), .memBus(memBus),
        .memRdata(memRdata), .cwWrite(cwWrite), .cwChan(cwChan), .cwSel(cwSel), .cwData(cwData),
        .cwEnable(cwEnable), .blockIrq(blockIrq));
    pio_dev_model pio_dev_model_inst (.clk(clk), .devBus(devBus), .memBus(memBus), .svcSet(svcSet),
        .svcUnits(svcUnits), .devData(devData), .memRdata(memRdata), .muxSvcReq(muxSvcReq));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================
    // shared tasks
    // ==========================================
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task automatic give_verdict();
        $display("counts: %0d checked, %0d mismatches", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic stuck(input string what);
        $display("BAD %s expected completion seen timeout", what);
        errors++;
        give_verdict();
    endtask
    // op held until procDone, dropped at the edge that shows it
    task automatic pioOp(input pio_op_e op, input logic [7:0] sel, input logic [15:0] acc);
        int n;
        n = 0;
        @(posedge clk);
        procReq <= '{op: op, sel: sel, data: acc};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (procDone !== 1'b1 && n < 40);
        procReq.op <= PIO_NONE;
        if (n >= 40)
            stuck("procDone");
    endtask
    task automatic loadCw(input logic [3:0] ch, input logic [15:0] addr, input logic [15:0] ctl);
        @(posedge clk);
        {cwWrite, cwChan, cwSel, cwData} <= {1'b1, ch, 1'b0, addr};
        @(posedge clk);
        {cwSel, cwData} <= {1'b1, ctl};
        @(posedge clk);
        cwWrite <= 1'b0;
    endtask
    task automatic grab(input string what);
        int k;
        k = 0;
        gapLow = 0;
        for (int n = 0; n < 200 && k < 2; n++)
        begin
            @(posedge clk);
            if (k == 1 && procHold !== 1'b1)
                gapLow++;
            if (devBus.wr === 1'b1)
            begin
                seen[k] = {devBus.sel, devBus.data};
                check(what, 16'h0001, {15'h0000, procHold});
                k++;
            end
        end
        if (k < 2)
            stuck(what);
    endtask
    // ==========================================
    // scenarios
    // ==========================================
    task automatic testOutIn();
        logic [7:0] c;
        pioOp(PIO_OUT, 8'h2A, 16'h1234);
        check("out select", 16'h002A, {8'h00, pio_dev_model_inst.lastSel});
        check("out data", 16'h1234, pio_dev_model_inst.lastData);
        c = pio_dev_model_inst.rdCnt;
        pioOp(PIO_IN, 8'hFF, 16'h0000);
        check("in data", {8'hFF, c}, procAcc);
        $display("test out_in done");
    endtask
    task automatic testAsk();
        devShareReq <= (255'h1 << 9) | (255'h1 << 4);
        repeat (4) @(posedge clk);
        pioOp(PIO_ASK, 8'h00, 16'h0000);
        check("ask first", 16'h0005, procAcc);
        devShareReq <= 255'h1 << 9;
        repeat (4) @(posedge clk);
        pioOp(PIO_ASK, 8'h00, 16'h0000);
        check("ask second", 16'h000A, procAcc);
        devShareReq <= 255'h0;
        $display("test ask done");
    endtask
    task automatic testMuxOut();
        pio_dev_model_inst.mem[8'h20] = 16'hBEEF;
        pio_dev_model_inst.mem[8'h30] = 16'hC0DE;
        loadCw(4'h1, 16'h0020, 16'h0001);
        loadCw(4'h3, 16'h0030, 16'h0001);
        {cwEnable, instrGap, svcSet, svcUnits} <= {16'h000A, 1'b0, 16'h000A, 4'h1};
        @(posedge clk);
        svcSet <= 16'h0000;
        repeat (20) @(posedge clk);
        check("no take without gap", 16'h0001, {12'h000, pio_dev_model_inst.units[1]});
        instrGap <= 1'b1;
        grab("word hold");
        check("first select", 16'h0002, {8'h00, seen[0][23:16]});
        check("first word", 16'hBEEF, seen[0][15:0]);
        check("second select", 16'h0004, {8'h00, seen[1][23:16]});
        check("second word", 16'hC0DE, seen[1][15:0]);
        repeat (4) @(posedge clk);
        check("end of block", 16'h000A, blockIrq);
        $display("test mux_out done");
    endtask
    task automatic testMuxByte();
        logic [7:0] c;
        logic [7:0] m0;
        int n;
        pio_dev_model_inst.mem[8'h50] = 16'h3C96;
        loadCw(4'h0, 16'h0040, 16'hC001);
        loadCw(4'h2, 16'h0050, 16'h4001);
        c = pio_dev_model_inst.rdCnt;
        m0 = pio_dev_model_inst.memWrCnt;
        {cwEnable, svcSet, svcUnits} <= {16'h000F, 16'h0005, 4'h2};
        @(posedge clk);
        svcSet <= 16'h0000;
        grab("byte hold");
        check("low byte first", 16'h0396, {seen[0][23:16], seen[0][7:0]});
        check("high byte next", 16'h033C, {seen[1][23:16], seen[1][7:0]});
        for (n = 0; n < 200 && pio_dev_model_inst.memWrCnt == m0; n++)
            @(posedge clk);
        if (n >= 200)
            stuck("byte pack");
        repeat (4) @(posedge clk);
        check("packed word", {c + 8'h01, c}, pio_dev_model_inst.mem[8'h40]);
        check("end of block", 16'h000F, blockIrq);
        $display("test mux_byte done");
    endtask
    // burst keeps the processor halted between words; then a single word-mode input
    task automatic testMuxBurst();
        logic [7:0] c;
        logic [7:0] m0;
        int n;
        pio_dev_model_inst.mem[8'h60] = 16'h5A01;
        pio_dev_model_inst.mem[8'h61] = 16'h5A02;
        loadCw(4'h4, 16'h0060, 16'h2002);
        loadCw(4'h5, 16'h0070, 16'h8001);
        c = pio_dev_model_inst.rdCnt;
        m0 = pio_dev_model_inst.memWrCnt;
        {cwEnable, svcSet, svcUnits} <= {16'h003F, 16'h0030, 4'h2};
        @(posedge clk);
        svcSet <= 16'h0000;
        grab("burst hold");
        check("burst selects", 16'h0505, {seen[0][23:16], seen[1][23:16]});
        check("burst first", 16'h5A01, seen[0][15:0]);
        check("burst second", 16'h5A02, seen[1][15:0]);
        check("burst kept hold", 16'h0000, 16'(gapLow));
        for (n = 0; n < 200 && pio_dev_model_inst.memWrCnt == m0; n++)
            @(posedge clk);
        if (n >= 200)
            stuck("word input");
        repeat (4) @(posedge clk);
        check("word input", {8'h06, c}, pio_dev_model_inst.mem[8'h70]);
        check("end of block", 16'h003F, blockIrq);
        $display("test mux_burst done");
    endtask
    initial
    begin
        {sysRst, instrGap, cwWrite, cwSel} = 4'hC;
        {cwChan, svcUnits} = 8'h00;
        {cwData, cwEnable, svcSet} = 48'h0;
        procReq = '0;
        devShareReq = 255'h0;
        repeat (8) @(posedge clk);
        sysRst <= 1'b0;
        check("idle outputs", 16'h0000, {13'h0000, procDone, procHold, devBus.wr});
        check("idle irq", 16'h0000, blockIrq);
        testOutIn();
        testAsk();
        testMuxOut();
        testMuxByte();
        testMuxBurst();
        give_verdict();
    end
endmodule // test_programmed_and_multiplexed_io_channel
`default_nettype wire
